// >>> src/atoc_top.sv
// telegram framer, tuning control and can scheduler with apb registers
//
// The implementer's own choices: register access over APB and the register addresses.
module atoc_top
  import atoc_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC_DEF
)(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // measured values
  input  wire logic        DECODED,
  input  wire logic        TAG_PRESENT,
  input  wire logic [31:0] TEL_CODE,
  input  wire logic [15:0] TEL_SUM,
  input  wire logic [15:0] DIFFERENCE_COIL_LEVEL,
  input  wire logic [7:0]  TEL_SUPPLY,
  input  wire logic [7:0]  TEL_CURRENT,
  input  wire logic [7:0]  TEL_TEMP,
  input  wire logic [7:0]  READS_PER_CROSSING,
  input  wire logic [15:0] TEL_RXF,
  input  wire logic [15:0] TEL_TXF,
  input  wire logic [15:0] TEL_STAT,
  // serial byte stream
  output logic [15:0]      SER_BAUD_DIV,
  output logic [7:0]       SER_TX_DATA,
  output logic             SER_TX_VALID,
  input  wire logic        SER_TX_READY,
  input  wire logic        SER_RX_CHAR,
  input  wire logic        SER_ACK,
  // antenna
  output logic [3:0]       TUNE_STEP,
  output logic             TX_ENABLE,
  output logic             TUNE_CHECK,
  // can controller
  output logic             CAN_TX_REQ,
  output logic [2:0]       CAN_TX_OBJ,
  output logic [28:0]      CAN_TX_ID,
  output logic             CAN_TX_EXT,
  input  wire logic        CAN_TX_ACK,
  input  wire logic        CAN_RX_RTR,
  input  wire logic [28:0] CAN_RX_ID,
  output logic [5:0]       CAN_BRP,
  output logic [1:0]       CAN_SJW,
  output logic [3:0]       CAN_TSEG1,
  output logic [2:0]       CAN_TSEG2
);
  // ****************************************
  // register state
  // ****************************************
  logic [31:0] ser_cfg_q;
  logic [31:0] ser_tel_q;
  logic [31:0] ser_act_q;
  logic [31:0] tel_act_q;
  logic [3:0]  step_q;
  logic        auto_q;
  logic        txon_q;
  logic        sess_q;
  logic [31:0] can_cfg_q;
  logic [28:0] id_q [0:3];
  logic [9:0]  can_per_q;
  logic        ack_to_q;
  logic        chr_to_q;
  logic        wr;
  logic        rd_ok;

  assign wr = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  assign rd_ok = PADDR[1:0] == 2'b00 && PADDR <= A_STATUS;
  assign PSLVERR = PSEL && PENABLE && !rd_ok;

  // active serial fields
  logic       lsb_first;
  logic [1:0] proc_sel;
  logic       ser_cont;
  logic [7:0] chr_dly;
  logic [10:0] ack_dly;
  logic [12:0] mask;
  logic [9:0]  ser_per;
  assign lsb_first = ser_act_q[1];
  assign proc_sel  = ser_act_q[3:2];
  assign ser_cont  = ser_act_q[4];
  assign chr_dly   = ser_act_q[15:8];
  assign ack_dly   = ser_act_q[26:16];
  assign mask      = tel_act_q[12:0];
  assign ser_per   = tel_act_q[25:16];

  // shadow copies; restart bit stands in for a power cycle
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      ser_cfg_q <= SER_CFG_RST;
      ser_tel_q <= SER_TEL_RST;
      ser_act_q <= SER_CFG_RST;
      tel_act_q <= SER_TEL_RST;
    end
    else
    begin
      if (wr && PADDR == A_SER_CFG)
        ser_cfg_q <= PWDATA;
      if (wr && PADDR == A_SER_TEL)
        ser_tel_q <= {1'b0, PWDATA[30:0]};
      if (wr && PADDR == A_SER_TEL && PWDATA[31])
      begin
        ser_act_q <= ser_cfg_q;
        tel_act_q <= ser_tel_q;
      end
    end

  // ****************************************
  // tuning and transmitter switch
  // ****************************************
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      step_q <= 4'h7;
      auto_q <= 1'b0;
      txon_q <= 1'b1;
      sess_q <= 1'b0;
    end
    else if (wr && PADDR == A_TUNE)
    begin
      auto_q <= PWDATA[4];
      sess_q <= PWDATA[6];
      txon_q <= (sess_q && !PWDATA[6]) ? 1'b1 : PWDATA[5];
      if (PWDATA[8] && step_q != 4'hf)
        step_q <= step_q + 4'h1;
      else if (PWDATA[9] && step_q != 4'h0)
        step_q <= step_q - 4'h1;
      else if (!PWDATA[8] && !PWDATA[9])
        step_q <= PWDATA[3:0];
    end

  assign TUNE_STEP = step_q;
  assign TX_ENABLE = txon_q;

  // ****************************************
  // can configuration
  // ****************************************
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      can_cfg_q <= CAN_CFG_RST;
      id_q      <= '{29'd10, 29'd0, 29'd0, 29'd7};
      can_per_q <= 10'd8;
    end
    else if (wr)
    begin
      if (PADDR == A_CAN_CFG)
      begin
        can_cfg_q <= PWDATA;
        if (PWDATA[19:16] < TSEG1_MIN)
          can_cfg_q[19:16] <= TSEG1_MIN;
        if (PWDATA[22:20] < TSEG2_MIN)
          can_cfg_q[22:20] <= TSEG2_MIN;
      end
      if (PADDR == A_CAN_ID)
        id_q[0] <= PWDATA[28:0];
      if (PADDR == A_CAN_IDA)
        id_q[1] <= PWDATA[28:0];
      if (PADDR == A_CAN_IDB)
        id_q[2] <= PWDATA[28:0];
      if (PADDR == A_CAN_IDD)
        id_q[3] <= PWDATA[28:0];
      if (PADDR == A_CAN_PER)
        can_per_q <= PWDATA[9:0];
    end

  logic can_en;
  logic can_ext;
  logic can_cont;
  logic can_rem;
  assign can_en   = can_cfg_q[0];
  assign can_ext  = can_cfg_q[1];
  assign can_cont = can_cfg_q[2];
  assign can_rem  = can_cfg_q[3];

  // bit timing: manual fields or one of the standard rates
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      CAN_BRP   <= 6'd1;
      CAN_SJW   <= 2'd0;
      CAN_TSEG1 <= TSEG1_MIN;
      CAN_TSEG2 <= TSEG2_MIN;
    end
    else if (can_cfg_q[7])
    begin
      CAN_BRP   <= can_cfg_q[13:8];
      CAN_SJW   <= can_cfg_q[15:14];
      CAN_TSEG1 <= can_cfg_q[19:16];
      CAN_TSEG2 <= can_cfg_q[22:20];
    end
    else
    begin
      {CAN_BRP, CAN_TSEG1, CAN_TSEG2} <= bt_of(can_cfg_q[6:4]);
      CAN_SJW <= 2'd0;
    end

  // ****************************************
  // millisecond time base
  // ****************************************
  logic [15:0] pre_q;
  logic        ms;
  assign ms = pre_q == 16'(MS_CYCLES - 1);
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      pre_q <= '0;
    else
      pre_q <= ms ? '0 : pre_q + 16'h1;

  // data periods, counted in ms
  logic [9:0] sp_q;
  logic [9:0] cp_q;
  logic       ser_tick;
  logic       can_tick;
  assign ser_tick = ms && sp_q + 10'd1 >= ser_per;
  assign can_tick = ms && cp_q + 10'd1 >= can_per_q;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      sp_q <= '0;
      cp_q <= '0;
    end
    else if (ms)
    begin
      sp_q <= ser_tick ? '0 : sp_q + 10'd1;
      cp_q <= can_tick ? '0 : cp_q + 10'd1;
    end

  // ****************************************
  // auto-tune schedule
  // ****************************************
  logic [13:0] at_q;
  logic        at_first_q;
  logic        at_due;
  assign at_due = ms && at_q + 14'd1 >=
                  (at_first_q ? AT_FIRST_MS : AT_REPEAT_MS);
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      at_q       <= '0;
      at_first_q <= 1'b1;
      TUNE_CHECK <= 1'b0;
    end
    else
    begin
      TUNE_CHECK <= auto_q && at_due && (at_first_q || !TAG_PRESENT);
      if (!auto_q)
        at_q <= '0;
      else if (at_due)
      begin
        at_q       <= '0;
        at_first_q <= 1'b0;
      end
      else if (ms)
        at_q <= at_q + 14'd1;
    end

  // ****************************************
  // serial telegram framer
  // ****************************************
  atoc_ser_t   st_q;
  logic [7:0]  snap_q [0:TEL_BYTES-1];
  logic [3:0]  el_q;
  logic        hi_q;
  logic [10:0] ack_q;
  logic        adv;
  logic        el_end;
  logic [4:0]  idx;

  assign idx = el_off(el_q) +
               5'(el_two(el_q) && (hi_q ^ lsb_first));
  assign SER_TX_VALID = st_q == SR_SEND && mask[el_q];
  assign SER_TX_DATA  = snap_q[idx];
  assign adv    = st_q == SR_SEND && (!mask[el_q] || SER_TX_READY);
  assign el_end = !mask[el_q] || !el_two(el_q) || hi_q;

  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      st_q     <= SR_IDLE;
      el_q     <= '0;
      hi_q     <= 1'b0;
      ack_q    <= '0;
      ack_to_q <= 1'b0;
      snap_q   <= '{default: 8'h00};
    end
    else
    begin
      if (wr && PADDR == A_STATUS && PWDATA[1])
        ack_to_q <= 1'b0;
      unique case (st_q)
        SR_IDLE:
          if (proc_sel != PROC_MON &&
              (ser_cont ? ser_tick : DECODED))
          begin
            st_q   <= SR_SEND;
            el_q   <= '0;
            hi_q   <= 1'b0;
            snap_q <= '{STX_BYTE, 8'h00, 8'h00,
                        TEL_CODE[31:24], TEL_CODE[23:16],
                        TEL_CODE[15:8], TEL_CODE[7:0],
                        TEL_SUM[15:8], TEL_SUM[7:0],
                        DIFFERENCE_COIL_LEVEL[15:8],
                        DIFFERENCE_COIL_LEVEL[7:0],
                        TEL_SUPPLY, TEL_CURRENT, TEL_TEMP,
                        READS_PER_CROSSING,
                        TEL_RXF[15:8], TEL_RXF[7:0],
                        TEL_TXF[15:8], TEL_TXF[7:0],
                        TEL_STAT[15:8], TEL_STAT[7:0]};
          end
        SR_SEND:
          if (adv)
          begin
            hi_q <= !el_end;
            if (el_end)
            begin
              el_q <= el_q + 4'h1;
              if (el_q == EL_LAST)
              begin
                ack_q <= '0;
                st_q  <= proc_sel == PROC_ACK ? SR_WACK : SR_IDLE;
              end
            end
          end
        SR_WACK:
          if (SER_ACK)
            st_q <= SR_IDLE;
          else if (ms)
          begin
            ack_q <= ack_q + 11'd1;
            if (ack_q + 11'd1 >= ack_dly)
            begin
              ack_to_q <= 1'b1;
              st_q     <= SR_IDLE;
            end
          end
      endcase
    end

  // incoming character timeout, armed by each received character
  logic [7:0] chr_q;
  logic       chr_arm_q;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      chr_q     <= '0;
      chr_arm_q <= 1'b0;
      chr_to_q  <= 1'b0;
    end
    else if (SER_RX_CHAR)
    begin
      chr_q     <= '0;
      chr_arm_q <= 1'b1;
    end
    else
    begin
      if (wr && PADDR == A_STATUS && PWDATA[2])
        chr_to_q <= 1'b0;
      if (chr_arm_q && ms)
      begin
        chr_q <= chr_q + 8'd1;
        if (chr_q + 8'd1 >= chr_dly)
        begin
          chr_arm_q <= 1'b0;
          chr_to_q  <= 1'b1;
        end
      end
    end

  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      SER_BAUD_DIV <= DIV_LO;
    else
      SER_BAUD_DIV <= ser_act_q[0] ? DIV_HI : DIV_LO;

  // ****************************************
  // can frame scheduler
  // ****************************************
  logic       cbusy_q;
  logic [2:0] obj_q;
  logic       rtr_hit;
  logic [2:0] nxt;
  logic [28:0] id_mask;
  assign id_mask = can_ext ? 29'h1fffffff : 29'h000007ff;
  assign rtr_hit = can_rem && CAN_RX_RTR &&
                   (CAN_RX_ID & id_mask) == (id_q[0] & id_mask);
  // further objects follow object 1 when enabled in bits 26..24, except in remote mode
  always_comb
  begin
    nxt = 3'd0;
    for (int i = 3; i >= 1; i--)
      if (can_cfg_q[23 + i] && 3'(i + 1) > obj_q)
        nxt = 3'(i + 1);
  end

  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      cbusy_q <= 1'b0;
      obj_q   <= 3'd1;
    end
    else if (!can_en)
      cbusy_q <= 1'b0;
    else if (!cbusy_q)
    begin
      obj_q <= 3'd1;
      if (can_rem ? rtr_hit : (can_cont ? can_tick : DECODED))
        cbusy_q <= 1'b1;
    end
    else if (CAN_TX_ACK)
    begin
      if (nxt != 3'd0 && !can_rem)
        obj_q <= nxt;
      else
        cbusy_q <= 1'b0;
    end

  assign CAN_TX_REQ = cbusy_q && can_en;
  assign CAN_TX_OBJ = obj_q;
  assign CAN_TX_ID  = id_q[2'(obj_q - 3'd1)] & id_mask;
  assign CAN_TX_EXT = can_ext;

  // ****************************************
  // read back
  // ****************************************
  always_comb
  begin
    PRDATA = '0;
    unique case (PADDR)
      A_SER_CFG: PRDATA = ser_cfg_q;
      A_SER_TEL: PRDATA = ser_tel_q;
      A_TUNE:    PRDATA = {25'd0, sess_q, txon_q, auto_q, step_q};
      A_CAN_CFG: PRDATA = can_cfg_q;
      A_CAN_ID:  PRDATA = {3'd0, id_q[0]};
      A_CAN_IDA: PRDATA = {3'd0, id_q[1]};
      A_CAN_IDB: PRDATA = {3'd0, id_q[2]};
      A_CAN_IDD: PRDATA = {3'd0, id_q[3]};
      A_CAN_PER: PRDATA = {22'd0, can_per_q};
      A_STATUS:  PRDATA = {27'd0, cbusy_q, 1'b0, chr_to_q,
                           ack_to_q, st_q != SR_IDLE};
      default:   PRDATA = '0;
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_BAUD: assert property (##1 SER_BAUD_DIV ==
    ($past(ser_act_q[0]) ? DIV_HI : DIV_LO)) else $error("baud divisor");
  AST_MON_QUIET: assert property (proc_sel == PROC_MON && st_q == SR_IDLE
    |=> !SER_TX_VALID) else $error("output in config-only mode");
  AST_HOLD: assert property (SER_TX_VALID && !SER_TX_READY
    |=> SER_TX_VALID && $stable(SER_TX_DATA)) else $error("byte dropped");
  AST_MASKED: assert property (SER_TX_VALID |-> mask[el_q])
    else $error("masked element sent");
  AST_STX: assert property (SER_TX_VALID && el_q == 4'd0
    |-> SER_TX_DATA == STX_BYTE) else $error("start byte wrong");
  AST_CAN_OFF: assert property (!can_en |-> !CAN_TX_REQ)
    else $error("can frame while disabled");
  AST_TX_BACK: assert property ($fell(sess_q) |-> TX_ENABLE)
    else $error("transmitter not restored");
  AST_ACK_WAIT: assert property (st_q == SR_WACK && SER_ACK
    |=> st_q == SR_IDLE && !$rose(ack_to_q)) else $error("ack not taken");
  AST_ID11: assert property (CAN_TX_REQ && !CAN_TX_EXT
    |-> CAN_TX_ID[28:11] == '0) else $error("standard id too wide");

  COV_TEL: cover property (st_q == SR_SEND ##1 st_q == SR_WACK);
  COV_ACK_TO: cover property ($rose(ack_to_q));
  COV_RTR: cover property (rtr_hit ##1 CAN_TX_REQ);
  COV_TUNE: cover property (TUNE_CHECK);
endmodule

// >>> src/atoc_pkg.sv
// constants, field layouts and helpers for the antenna telegram output block
package atoc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS      = 50;
  localparam int MS_NS       = 1000000;
  localparam int MS_CYC_DEF  = MS_NS / CLK_NS;
  localparam int CLK_HZ      = 1000000000 / CLK_NS;
  localparam int BAUD_LO     = 9600;
  localparam int BAUD_HI     = 19200;
  localparam logic [15:0] DIV_LO = 16'(CLK_HZ / BAUD_LO);
  localparam logic [15:0] DIV_HI = 16'(CLK_HZ / BAUD_HI);
  localparam logic [13:0] AT_FIRST_MS  = 14'd16000;
  localparam logic [13:0] AT_REPEAT_MS = 14'd10000;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] A_SER_CFG = 8'h00;
  localparam logic [7:0] A_SER_TEL = 8'h04;
  localparam logic [7:0] A_TUNE    = 8'h08;
  localparam logic [7:0] A_CAN_CFG = 8'h0c;
  localparam logic [7:0] A_CAN_ID  = 8'h10;
  localparam logic [7:0] A_CAN_IDA = 8'h14;
  localparam logic [7:0] A_CAN_IDB = 8'h18;
  localparam logic [7:0] A_CAN_IDD = 8'h1c;
  localparam logic [7:0] A_CAN_PER = 8'h20;
  localparam logic [7:0] A_STATUS  = 8'h24;
  localparam logic [1:0] PROC_ACK  = 2'h0;
  localparam logic [1:0] PROC_TRN  = 2'h1;
  localparam logic [1:0] PROC_MON  = 2'h2;
  localparam logic [31:0] SER_CFG_RST = 32'h06900000 | 32'h0000dc00;
  localparam logic [31:0] SER_TEL_RST = 32'h00081fff;
  // can off, continuous, 1000 kbit/s, tseg1 6, tseg2 1
  localparam logic [31:0] CAN_CFG_RST = 32'h00160054;
  localparam logic [7:0]  STX_BYTE    = 8'h02;
  localparam int TEL_ELEMS = 13;
  localparam int TEL_BYTES = 21;
  localparam logic [3:0]  EL_LAST = 4'(TEL_ELEMS - 1);
  localparam logic [3:0]  TSEG1_MIN = 4'h2;
  localparam logic [2:0]  TSEG2_MIN = 3'h1;

  // first byte of each element, 0-based
  function automatic logic [4:0] el_off(input logic [3:0] e);
    logic [4:0] t [0:12];
    t = '{5'd0, 5'd1, 5'd3, 5'd5, 5'd7, 5'd9, 5'd11, 5'd12, 5'd13,
          5'd14, 5'd15, 5'd17, 5'd19};
    return t[e];
  endfunction

  function automatic logic el_two(input logic [3:0] e);
    return !(e == 4'd0 || (e >= 4'd6 && e <= 4'd9));
  endfunction

  // {brp, tseg1, tseg2} for the six standard rates, 1000 kbit/s default
  function automatic logic [12:0] bt_of(input logic [2:0] sel);
    unique case (sel)
      3'h0:    return {6'd49, 4'd13, 3'd4};
      3'h1:    return {6'd39, 4'd6, 3'd1};
      3'h2:    return {6'd15, 4'd6, 3'd1};
      3'h3:    return {6'd7, 4'd6, 3'd1};
      3'h4:    return {6'd3, 4'd6, 3'd1};
      default: return {6'd1, 4'd6, 3'd1};
    endcase
  endfunction

  typedef enum logic [1:0] {SR_IDLE, SR_SEND, SR_WACK} atoc_ser_t;
endpackage

// >>> testbench/atoc_host.sv
// host side model: serial byte sink with acknowledge, can frame acknowledge
module atoc_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // serial byte stream
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            ser_ack,
  input  wire logic       slow,
  // can controller
  input  wire logic       can_req,
  output logic            can_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [$];
  logic [4:0] gap_q;
  // ****************************************
  // sink and acknowledges
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_ready <= 1'b0;
      ser_ack  <= 1'b0;
      can_ack  <= 1'b0;
      gap_q    <= 5'h00;
    end
    else
    begin
      // slow host stalls every other cycle
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready)
        got.push_back(tx_data);
      // long gap so skipped elements never look like telegram end
      gap_q   <= tx_valid ? 5'h01 : (gap_q != 5'h00 ? gap_q + 5'h01 : 5'h00);
      ser_ack <= (gap_q == 5'h14);
      can_ack <= can_req && !can_ack;
    end
  end
endmodule

// >>> testbench/atoc_top_bench.sv
// self-checking bench for the antenna telegram output block
module atoc_top_bench
  import atoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, dec = 1'b0, tag = 1'b0, rxc = 1'b0;
  logic        rtr = 1'b0, slow = 1'b0, pready, pslverr, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [31:0] code = 32'h1234abcd;
  logic [15:0] mv = 16'h5a3c;
  logic [28:0] rx_id = 29'h0, cid;
  logic [15:0] baud;
  logic [7:0]  txd;
  logic [3:0]  step, ts1;
  logic [2:0]  cobj, ts2;
  logic [5:0]  bit_rate_divider;
  logic [1:0]  sjw;
  logic        txv, txr, sack, txen, tchk, creq, cext, cack;
  int          err_total = 0;
  int          samples_checked = 0;

  atoc_top #(.MS_CYCLES(2)) DUT (
    .CLK(clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DECODED(dec), .TAG_PRESENT(tag), .TEL_CODE(code),
    .TEL_SUM(mv), .DIFFERENCE_COIL_LEVEL(~mv), .TEL_SUPPLY(mv[7:0]),
    .TEL_CURRENT(mv[15:8]), .TEL_TEMP(~mv[7:0]),
    .READS_PER_CROSSING(~mv[15:8]), .TEL_RXF(mv), .TEL_TXF(~mv),
    .TEL_STAT(code[31:16]), .SER_BAUD_DIV(baud), .SER_TX_DATA(txd),
    .SER_TX_VALID(txv), .SER_TX_READY(txr), .SER_RX_CHAR(rxc),
    .SER_ACK(sack), .TUNE_STEP(step), .TX_ENABLE(txen), .TUNE_CHECK(tchk),
    .CAN_TX_REQ(creq), .CAN_TX_OBJ(cobj), .CAN_TX_ID(cid), .CAN_TX_EXT(cext),
    .CAN_TX_ACK(cack), .CAN_RX_RTR(rtr), .CAN_RX_ID(rx_id), .CAN_BRP(bit_rate_divider),
    .CAN_SJW(sjw), .CAN_TSEG1(ts1), .CAN_TSEG2(ts2)
  );
  atoc_host host (
    .clk(clk), .rst_n(rst_n), .tx_data(txd), .tx_valid(txv),
    .tx_ready(txr), .ser_ack(sack), .slow(slow), .can_req(creq),
    .can_ack(cack)
  );

  always #25 clk = ~clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic pulse_dec;
    @(posedge clk);
    dec <= 1'b1;
    @(posedge clk);
    dec <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b1, input logic [7:0] b2,
                      input int cnt);
    int n;
    n = 0;
    host.got.delete();
    pulse_dec();
    while (host.got.size() < 3 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    repeat (30) @(negedge clk);
    chk(32'(host.got.size()), 32'(cnt));
    if (cnt >= 3)
    begin
      chk(32'(host.got[0]), 32'(STX_BYTE));
      chk(32'(host.got[1]), 32'(b1));
      chk(32'(host.got[2]), 32'(b2));
    end
  endtask
  task automatic req_seen(input int n, output logic s);
    s = 1'b0;
    repeat (n)
    begin
      @(negedge clk);
      if (creq === 1'b1)
        s = 1'b1;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic s;
    apb(1'b0, A_SER_CFG, 32'h0);
    chk(r, 32'h0690dc00);
    apb(1'b0, A_SER_TEL, 32'h0);
    chk(r, 32'h00081fff);
    apb(1'b0, A_CAN_ID, 32'h0);
    chk(r, 32'd10);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(e), 32'h1);
    chk(32'(baud), 32'd2083);
    chk(32'(step), 32'd7);
    chk(32'(txen), 32'h1);
    chk(32'(ts1), 32'd6);
    apb(1'b0, A_CAN_CFG, 32'h0);
    chk(32'(r[0]), 32'h0);
    req_seen(40, s);
    chk(32'(s), 32'h0);
  endtask
  task automatic t_serial;
    // acknowledged procedure with the full telegram
    send(8'h00, 8'h00, 21);
    repeat (30) @(negedge clk);
    apb(1'b0, A_STATUS, 32'h0);
    chk(32'(r[1:0]), 32'h0);
    apb(1'b1, A_SER_TEL, 32'h00080009);
    apb(1'b1, A_SER_CFG, 32'h0690dc04);
    apb(1'b1, A_SER_TEL, 32'h80080009);
    send(8'hab, 8'hcd, 3);
    apb(1'b1, A_SER_CFG, 32'h0690dc07);
    @(negedge clk);
    chk(32'(baud), 32'd2083);
    send(8'hab, 8'hcd, 3);
    apb(1'b1, A_SER_TEL, 32'h80080009);
    repeat (2) @(negedge clk);
    chk(32'(baud), 32'd1041);
    slow <= 1'b1;
    send(8'hcd, 8'hab, 3);
    // a stalling host would stretch a telegram past one period
    @(posedge clk);
    slow <= 1'b0;
    // continuous: 16 cycle period, so ten telegrams in 160 cycles
    apb(1'b1, A_SER_CFG, 32'h0690dc14);
    apb(1'b1, A_SER_TEL, 32'h80080009);
    host.got.delete();
    repeat (160) @(negedge clk);
    chk(32'(host.got.size() >= 27 && host.got.size() <= 33), 32'h1);
    apb(1'b1, A_SER_CFG, 32'h0690dc08);
    apb(1'b1, A_SER_TEL, 32'h80080009);
    repeat (20) @(negedge clk);
    send(8'h00, 8'h00, 0);
  endtask
  task automatic t_tune;
    apb(1'b1, A_TUNE, 32'h4f);
    @(negedge clk);
    chk(32'(step), 32'd15);
    chk(32'(txen), 32'h0);
    apb(1'b1, A_TUNE, 32'h140);
    @(negedge clk);
    chk(32'(step), 32'd15);
    apb(1'b1, A_TUNE, 32'h240);
    @(negedge clk);
    chk(32'(step), 32'd14);
    apb(1'b1, A_TUNE, 32'h0);
    @(negedge clk);
    chk(32'(txen), 32'h1);
    apb(1'b1, A_TUNE, 32'h200);
    @(negedge clk);
    chk(32'(step), 32'd0);
  endtask
  task automatic t_char;
    @(posedge clk);
    rxc <= 1'b1;
    @(posedge clk);
    rxc <= 1'b0;
    repeat (400) @(posedge clk);
    apb(1'b0, A_STATUS, 32'h0);
    chk(32'(r[2]), 32'h0);
    repeat (100) @(posedge clk);
    apb(1'b0, A_STATUS, 32'h0);
    chk(32'(r[2]), 32'h1);
  endtask
  task automatic t_can;
    logic s;
    apb(1'b1, A_CAN_CFG, 32'h007fff80);
    repeat (2) @(negedge clk);
    chk({bit_rate_divider, sjw, ts1, ts2}, 32'h00007fff);
    apb(1'b1, A_CAN_CFG, 32'h00003f80);
    repeat (2) @(negedge clk);
    chk(32'(ts1), 32'(TSEG1_MIN));
    pulse_dec();
    req_seen(60, s);
    chk(32'(s), 32'h0);
    apb(1'b1, A_CAN_CFG, 32'h51);
    repeat (2) @(negedge clk);
    chk(32'(bit_rate_divider), 32'd1);
    pulse_dec();
    req_seen(3, s);
    chk({s, cobj, cext, cid}, {1'b1, 3'd1, 1'b0, 29'd10});
    repeat (40) @(negedge clk);
    apb(1'b1, A_CAN_ID, 32'h1abcdef1);
    apb(1'b1, A_CAN_CFG, 32'h5f);
    req_seen(60, s);
    chk(32'(s), 32'h0);
    @(posedge clk);
    rtr   <= 1'b1;
    rx_id <= 29'h1abcdef0;
    @(posedge clk);
    rtr <= 1'b0;
    req_seen(20, s);
    chk(32'(s), 32'h0);
    @(posedge clk);
    rtr   <= 1'b1;
    rx_id <= 29'h1abcdef1;
    @(posedge clk);
    rtr <= 1'b0;
    req_seen(3, s);
    chk({s, cext, cid}, {1'b1, 1'b1, 29'h1abcdef1});
  endtask
  task automatic t_auto;
    int n;
    n = 0;
    apb(1'b1, A_TUNE, 32'h30);
    while (tchk !== 1'b1 && n < 40000)
    begin
      @(negedge clk);
      n++;
    end
    // sixteen seconds at two cycles per ms, a few cycles of slack
    chk(32'(n >= 31996 && n <= 32004), 32'h1);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tchk !== 1'b1 && n < 25000);
    // ten seconds at two cycles per ms, one cycle of slack
    chk(32'(n >= 19999 && n <= 20001), 32'h1);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_serial();
    t_tune();
    t_char();
    t_can();
    t_auto();
    wrap_up();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule
